// >>> sep_checker.sv
// Purpose: Port-level assertions for the two-wire memory slave
// Assumes: Bound to every sep_slave instance
// Notes: Write cycle length follows the bound WRITE_CYC
`timescale 1ns/10ps
module sep_checker #(
    parameter int unsigned WRITE_CYC = 50
) (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset
    input wire logic scl_i, // Bus clock
    input wire logic sda_i, // Data line level
    input wire logic sda_o, // Drive value
    input wire logic sda_oe_n, // Pull enable
    input wire logic write_protect_input, // Write protect
    input wire logic write_busy, // Write cycle
    input wire logic id_locked // Lock flag
);
    logic [31:0] busy_cnt_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) busy_cnt_q <= '0;
        else if (write_busy) busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
        else busy_cnt_q <= '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    chk_drive_zero: assert property (sda_o == 1'b0) else $error("drive not zero");
    chk_busy_quiet: assert property (write_busy |-> sda_oe_n)
        else $error("line pulled during write");
    chk_busy_start: assert property ($rose(write_busy) |-> scl_i && sda_i)
        else $error("write cycle without stop");
    chk_wp_block: assert property ($rose(write_busy) |-> !write_protect_input)
        else $error("write while protected");
    chk_busy_len: assert property ($fell(write_busy) |-> busy_cnt_q == WRITE_CYC)
        else $error("write cycle length wrong");
    chk_busy_cap: assert property (busy_cnt_q <= WRITE_CYC)
        else $error("write cycle too long");
    chk_drive_steady: assert property ($changed(sda_oe_n) |-> !scl_i)
        else $error("drive moved with clock high");
    chk_ack_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*4])
        else $error("ack too short");
    chk_id_sticky: assert property (id_locked |=> id_locked)
        else $error("lock cleared");
    chk_reset_quiet: assert property ($fell(rst) |-> sda_oe_n [*3])
        else $error("drive after reset");
    cover property ($rose(write_busy));
    cover property ($rose(id_locked));
    cover property ($fell(sda_oe_n) && write_protect_input);
endmodule // sep_checker

bind sep_slave sep_checker #(.WRITE_CYC(WRITE_CYC)) u_sep_checker (.clock, .rst, .scl_i,
    .sda_i, .sda_o, .sda_oe_n, .write_protect_input, .write_busy, .id_locked);

// >>> sep_master.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Data line has a pull-up
// Notes: Reports the ninth bit of every byte
`timescale 1ns/10ps
module sep_master #(
    parameter int HALF = 8 // Clocks per bus clock half period
) (
    input wire logic clock, // System clock
    input wire logic sda_i, // Resolved data line
    output logic scl_o, // Bus clock
    output logic sda_low, // Pulls data low
    output logic ack_stb, // Ninth bit sampled
    output logic ack_val // Ninth bit was low
);
    initial begin
        scl_o = 1'b1;
        sda_low = 1'b0;
        ack_stb = 1'b0;
        ack_val = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic start_c();
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
    endtask
    task automatic clk_bit(input logic b, input logic last);
        tick(HALF / 2);
        sda_low = !b;
        tick(HALF / 2);
        scl_o = 1'b1;
        tick(1);
        ack_val = !sda_i;
        ack_stb = last;
        tick(1);
        ack_stb = 1'b0;
        tick(HALF - 2);
        scl_o = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) clk_bit(b[i], 1'b0);
        clk_bit(1'b1, 1'b1);
    endtask
    task automatic stop_c();
        tick(HALF / 2);
        sda_low = 1'b1;
        tick(HALF / 2);
        scl_o = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF * 2);
    endtask
endmodule // sep_master

// >>> sep_pkg.sv
// Purpose: Constants for the serial EEPROM two-wire slave front end
// Assumes: System clock 200 MHz, bus clock up to 1 MHz
// Notes: Write cycle length is given in microseconds
package sep_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned WRITE_TIME_US = 4000;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int unsigned ARRAY_BYTES = 256;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned ID_BYTES = 16;
    localparam logic [3:0] TYPE_MAIN = 4'h000a;
    localparam logic [3:0] TYPE_ID = 4'h000b;
    localparam logic [7:0] BYTE_RESET = 8'h00ff;
    localparam logic [3:0] BITCNT_RESET = 4'h0000;
    localparam logic [7:0] LOCK_ADDR_BIT = 8'h0080;
    typedef enum logic [6:0] {
        SEP_IDLE = 7'b000_0001,
        SEP_DEVSEL = 7'b000_0010,
        SEP_ADDR = 7'b000_0100,
        SEP_WDATA = 7'b000_1000,
        SEP_RDATA = 7'b001_0000,
        SEP_RACK = 7'b010_0000,
        SEP_BUSY = 7'b100_0000
    } sep_state_t;
endpackage

// >>> sep_slave.sv
// Purpose: Two-wire bus slave of a 2-Kbit byte-alterable memory
// Assumes: clock far faster than bus clock; pins are asynchronous
// Notes: Array bytes carry four Hamming check bits, corrected when read
//
// Behaviour
// R1 - 256 byte array, 16 pages of 16
// R2 - Separate 16 byte identification page
// R3 - Identification page lock is permanent
// R4 - Stored bytes carry error-correction protection; only array bytes get check bits here, the identification page has none
// R5 - Works up to 1 MHz bus clock
// R6 - Bus clock captures and launches data bits
// R7 - Data pin is open-drain only
// R8 - Straps compared with select bits 3..1
// R9 - Unconnected strap reads as zero
// R10 - Write-protect high blocks array writes
// R11 - Write-protect low or open enables writes
// R12 - Protected: ack select, address; not data
// R13 - Device is only a slave
// R14 - Start: data falls while clock high
// R15 - Master starts every transfer with Start
// R16 - Watch Start always except write cycle
// R17 - Stop: data rises while clock high
// R18 - Stop ends transaction, wait for Start
// R19 - Stop after written data starts programming
// R20 - Ack only type 1010 or 1011
// R21 - Receiver acks during ninth clock
// R22 - Sample at clock rise, change when low
// R23 - Select bit 0 is direction, 1 reads
// R24 - Unaddressed device keeps data released
// R25 - Write cycle is a busy interval
`timescale 1ns/10ps
module sep_slave
    import sep_pkg::*;
#(
    parameter int unsigned WRITE_CYC = WRITE_CYCLES
) (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic scl_i, // Bus clock pin
    input wire logic sda_i, // Bus data pin level
    output logic sda_o, // Data drive value, always 0
    output logic sda_oe_n, // Low pulls data line low
    input wire logic chip_select_strap_2, // Strap, pulled low when open
    input wire logic chip_select_strap_1, // Strap, pulled low when open
    input wire logic chip_select_strap_0, // Strap, pulled low when open
    input wire logic write_protect_input, // High blocks writes
    output logic write_busy, // Internal write cycle running
    output logic id_locked // Identification page locked
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] scl_s_q, sda_s_q;
    logic [2:0] strap_s1_q, strap_s_q;
    logic [1:0] wp_s_q;
    logic scl_d1_q, sda_d1_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scl_s_q <= 2'b11;
            sda_s_q <= 2'b11;
            strap_s1_q <= 3'b000; // R9
            strap_s_q <= 3'b000;
            wp_s_q <= 2'b00; // R11
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i}; // R5
            sda_s_q <= {sda_s_q[0], sda_i};
            strap_s1_q <= {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
            strap_s_q <= strap_s1_q;
            wp_s_q <= {wp_s_q[0], write_protect_input};
            scl_d1_q <= scl_s_q[1];
            sda_d1_q <= sda_s_q[1];
        end
    end
    logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev, wp;
    assign scl = scl_s_q[1];
    assign sda = sda_s_q[1];
    assign wp = wp_s_q[1];
    assign scl_rise = scl & ~scl_d1_q; // R6 R22
    assign scl_fall = ~scl & scl_d1_q; // R6
    assign start_ev = scl & scl_d1_q & sda_d1_q & ~sda; // R14
    assign stop_ev = scl & scl_d1_q & ~sda_d1_q & sda; // R17

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0] mem_q [ARRAY_BYTES]; // R1
    logic [3:0] ecc_q [ARRAY_BYTES]; // R4
    logic [7:0] id_q [ID_BYTES]; // R2
    logic [7:0] wbuf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] wvld_q;

    ////////////////////////////////////////////////////////////////////////
    // Byte engine
    sep_state_t state_q;
    logic [3:0] bitcnt_q;
    logic [7:0] shift_q, addr_q, rdbyte_q;
    logic id_sel_q, ack_slot_q, ack_q, wrote_q, lock_req_q, master_ack_q;
    logic [$clog2(WRITE_CYC+1)-1:0] busy_cnt_q;

    function automatic logic sel_match(input logic [7:0] b, input logic [2:0] st);
        sel_match = (b[7:4] == TYPE_MAIN || b[7:4] == TYPE_ID) // R20
            && (b[3:1] == st); // R8
    endfunction

    // Four Hamming check bits per array byte repair any single flipped bit
    function automatic logic [3:0] ecc_gen(input logic [7:0] d);
        ecc_gen[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        ecc_gen[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        ecc_gen[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        ecc_gen[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    endfunction
    function automatic logic [7:0] ecc_fix(input logic [7:0] d, input logic [3:0] c);
        logic [3:0] syn;
        syn = ecc_gen(d) ^ c;
        ecc_fix = d;
        case (syn)
            4'h0003: ecc_fix[0] = ~d[0];
            4'h0005: ecc_fix[1] = ~d[1];
            4'h0006: ecc_fix[2] = ~d[2];
            4'h0007: ecc_fix[3] = ~d[3];
            4'h0009: ecc_fix[4] = ~d[4];
            4'h000a: ecc_fix[5] = ~d[5];
            4'h000b: ecc_fix[6] = ~d[6];
            4'h000c: ecc_fix[7] = ~d[7];
            default: ecc_fix = d;
        endcase
    endfunction

    logic [7:0] rx_byte;
    assign rx_byte = {shift_q[6:0], sda};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= SEP_IDLE;
            bitcnt_q <= BITCNT_RESET;
            shift_q <= BYTE_RESET;
            addr_q <= 8'h0000;
            id_sel_q <= 1'b0;
            ack_slot_q <= 1'b0;
            ack_q <= 1'b0;
            wrote_q <= 1'b0;
            lock_req_q <= 1'b0;
            master_ack_q <= 1'b0;
            busy_cnt_q <= '0;
        end else if (state_q == SEP_BUSY) begin
            // Bus ignored entirely while programming
            if (busy_cnt_q == '0) begin // R25 R16
                state_q <= SEP_IDLE;
            end else begin
                busy_cnt_q <= busy_cnt_q - 1'b1;
            end
        end else if (stop_ev) begin
            ack_q <= 1'b0;
            ack_slot_q <= 1'b0;
            // Stop follows the tenth clock rise, which the bit counter has taken
            if (wrote_q && state_q == SEP_WDATA && bitcnt_q == 4'h0001) begin // R19
                state_q <= SEP_BUSY;
                busy_cnt_q <= ($clog2(WRITE_CYC+1))'(WRITE_CYC - 1);
            end else begin
                state_q <= SEP_IDLE; // R18
            end
        end else if (start_ev) begin // R16
            state_q <= SEP_DEVSEL;
            bitcnt_q <= 4'h0000;
            ack_q <= 1'b0;
            ack_slot_q <= 1'b0;
            wrote_q <= 1'b0;
            lock_req_q <= 1'b0;
        end else if (scl_rise && !ack_slot_q) begin
            shift_q <= rx_byte;
            bitcnt_q <= bitcnt_q + 4'h0001;
        end else if (scl_rise && ack_slot_q) begin
            master_ack_q <= ~sda; // R21
        end else if (scl_fall && ack_slot_q) begin
            // End of ninth clock: release line and advance
            ack_slot_q <= 1'b0;
            ack_q <= 1'b0;
            bitcnt_q <= 4'h0000;
            if (state_q == SEP_RACK) begin
                if (master_ack_q) begin
                    state_q <= SEP_RDATA;
                    addr_q <= addr_q + 8'h0001;
                end else begin
                    state_q <= SEP_IDLE;
                end
            end else if (state_q == SEP_DEVSEL && ack_q && shift_q[0]) begin
                state_q <= SEP_RDATA; // R23
                addr_q <= addr_q + 8'h0001;
            end else if (!ack_q && state_q != SEP_WDATA) begin
                state_q <= SEP_IDLE; // R24
            end
        end else if (scl_fall && bitcnt_q == 4'h0008 && state_q != SEP_IDLE) begin
            ack_slot_q <= 1'b1;
            case (state_q)
                SEP_DEVSEL: begin
                    ack_q <= sel_match(shift_q, strap_s_q);
                    id_sel_q <= (shift_q[7:4] == TYPE_ID);
                    if (shift_q[0]) begin // R23
                        state_q <= SEP_RACK;
                        addr_q <= addr_q - 8'h0001;
                        master_ack_q <= 1'b1;
                        ack_q <= 1'b0;
                        if (!sel_match(shift_q, strap_s_q)) begin
                            state_q <= SEP_IDLE;
                            ack_slot_q <= 1'b0;
                        end else begin
                            ack_q <= 1'b1;
                            state_q <= SEP_DEVSEL;
                        end
                    end else begin
                        state_q <= SEP_ADDR;
                    end
                end
                SEP_ADDR: begin
                    ack_q <= 1'b1; // R12
                    addr_q <= shift_q;
                    lock_req_q <= id_sel_q && (shift_q & LOCK_ADDR_BIT) != 8'h0000;
                    state_q <= SEP_WDATA;
                end
                SEP_WDATA: begin
                    ack_q <= !wp && !(id_sel_q && id_locked); // R12 R10 R3
                    if (!wp && !(id_sel_q && id_locked)) begin
                        wrote_q <= 1'b1;
                        addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h0001};
                    end
                end
                SEP_RDATA: begin
                    ack_q <= 1'b0;
                    state_q <= SEP_RACK;
                end
                default: begin
                    ack_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write buffer and programming
    logic wr_take;
    assign wr_take = state_q == SEP_WDATA && scl_fall && bitcnt_q == 4'h0008 && !ack_slot_q
        && !wp && !(id_sel_q && id_locked);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wvld_q <= '0;
            id_locked <= 1'b0;
        end else begin
            if (start_ev && state_q != SEP_BUSY) begin
                wvld_q <= '0;
            end else if (wr_take) begin
                wvld_q[addr_q[3:0]] <= 1'b1;
            end
            if (state_q == SEP_BUSY && busy_cnt_q == '0 && lock_req_q) begin
                id_locked <= 1'b1; // R3
            end
        end
    end
    always_ff @(posedge clock) begin
        if (wr_take) begin
            wbuf_q[addr_q[3:0]] <= shift_q;
        end
    end
    // Programming is committed at the end of the busy interval
    generate
        for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_prog
            always_ff @(posedge clock) begin
                if (state_q == SEP_BUSY && busy_cnt_q == '0 && wvld_q[i]
                    && !lock_req_q) begin // R19 R10
                    if (id_sel_q) begin
                        id_q[i] <= wbuf_q[i]; // R2
                    end else begin
                        mem_q[{addr_q[7:4], 4'(i)}] <= wbuf_q[i]; // R1
                        ecc_q[{addr_q[7:4], 4'(i)}] <= ecc_gen(wbuf_q[i]); // R4
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data and open-drain drive
    always_ff @(posedge clock) begin
        if (state_q == SEP_RDATA && bitcnt_q == 4'h0000) begin
            rdbyte_q <= id_sel_q ? id_q[addr_q[3:0]]
                : ecc_fix(mem_q[addr_q], ecc_q[addr_q]); // R4
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sda_oe_n <= 1'b1;
            sda_o <= 1'b0;
            write_busy <= 1'b0;
        end else begin
            write_busy <= state_q == SEP_BUSY; // R25
            sda_o <= 1'b0; // R7 R13
            if (state_q == SEP_IDLE || state_q == SEP_BUSY) begin
                sda_oe_n <= 1'b1; // R24 R16
            end else if (ack_slot_q) begin
                sda_oe_n <= ~ack_q; // R21
            end else if (state_q == SEP_RDATA && bitcnt_q < 4'h0008 && !scl) begin
                sda_oe_n <= rdbyte_q[3'(7 - bitcnt_q)]; // R6 R22
            end else if (state_q != SEP_RDATA) begin
                sda_oe_n <= 1'b1;
            end
        end
    end
endmodule // sep_slave

// >>> tb_top.sv
// Purpose: Self-checking bench for the two-wire memory slave
// Assumes: Bus clock period 80 ns
// Notes: Acks are queued by the driver and checked by a monitor
`timescale 1ns/10ps
module tb_top;
    import sep_pkg::*;
    localparam int unsigned WCYC = 600;
    logic clock, rst, scl, sda_low, ack_stb, ack_val, sda_o, sda_oe_n, wp, write_busy, id_locked;
    logic sda;
    logic [2:0] strap;
    logic exp_q[$];
    int mismatches, checks, busy_n;
    assign sda = (sda_low || (!sda_oe_n && !sda_o)) ? 1'b0 : 1'b1;
    sep_slave #(.WRITE_CYC(WCYC)) u_sep_slave (.clock, .rst, .scl_i(scl), .sda_i(sda), .sda_o,
        .sda_oe_n, .chip_select_strap_2(strap[2]), .chip_select_strap_1(strap[1]),
        .chip_select_strap_0(strap[0]), .write_protect_input(wp), .write_busy, .id_locked);
    sep_master u_sep_master (.clock, .sda_i(sda), .scl_o(scl), .sda_low, .ack_stb, .ack_val);
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(string name, logic seen, logic expv);
        checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", name, expv, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic frame(input logic [7:0] s, a, d, input int n, input logic [2:0] acks);
        logic [7:0] b[3];
        b = '{s, a, d};
        u_sep_master.start_c();
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(acks[i]);
            u_sep_master.send_byte(b[i]);
        end
        u_sep_master.stop_c();
    endtask
    task automatic wait_busy(input logic expv);
        repeat (WCYC + 40) @(negedge clock);
        check("write_busy", busy_n > 0, expv);
        if (expv) check("busy_len", busy_n == WCYC, 1'b1);
        busy_n = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(negedge clock) if (write_busy === 1'b1) busy_n++;
    always @(posedge clock) begin
        if (ack_stb === 1'b1 && exp_q.size() > 0) check("ack", ack_val, exp_q.pop_front());
    end
    initial begin
        #500_000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        logic [7:0] sm, si;
        rst = 1'b1;
        wp = 1'b0;
        busy_n = 0;
        void'($urandom(83764));
        strap = 3'($urandom());
        sm = {TYPE_MAIN, strap, 1'b0};
        si = {TYPE_ID, strap, 1'b0};
        repeat (5) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        frame(sm, 8'($urandom()), 8'($urandom()), 3, 3'b111);
        frame(sm, 8'h00_00, 8'h00_00, 1, 3'b000);
        wait_busy(1'b1);
        frame({TYPE_MAIN, strap ^ 3'($urandom_range(1, 7)), 1'b0}, 8'h00_01, 8'h00_55, 3,
            3'b000);
        wait_busy(1'b0);
        for (int t = 0; t < 16; t++) begin
            if (t != 10 && t != 11) frame({4'(t), strap, 1'b0}, 8'h00_00, 8'h00_00, 1, 3'b000);
        end
        frame(sm, 8'($urandom()), 8'h00_00, 2, 3'b011);
        wait_busy(1'b0);
        wp = 1'b1;
        frame(sm, 8'($urandom()), 8'($urandom()), 3, 3'b011);
        wait_busy(1'b0);
        wp = 1'b0;
        frame(si, 8'h00_80, 8'($urandom()), 3, 3'b111);
        wait_busy(1'b1);
        check("id_locked", id_locked, 1'b1);
        frame(si, 8'h00_02, 8'($urandom()), 3, 3'b011);
        wait_busy(1'b0);
        report_and_stop();
    end
endmodule // tb_top
